// ===== hw/slb_map.svh
// Constants for the serial line bus slave: field positions, codes, timing.
// Assumes a 40 MHz system clock; included by its bare name.
`ifndef SLB_MAP_SVH
`define SLB_MAP_SVH

// Bus widths
`define SLB_ADDR_W 18
`define SLB_DATA_W 16
`define SLB_STRAP_W 8
`define SLB_VSEL_W 6

// Select vector index {C1, A2, A1}
`define SLB_RD_RX_STAT 3'h0
`define SLB_RD_RX_BUF 3'h1
`define SLB_RD_TX_STAT 3'h2
`define SLB_RD_NONE 3'h3
`define SLB_WR_RX_STAT 3'h4
`define SLB_WR_RX_BUF 3'h5
`define SLB_WR_TX_STAT 3'h6
`define SLB_WR_TX_BUF 3'h7

// Status field positions
`define SLB_FLAG_BIT 7
`define SLB_IE_BIT 6
`define SLB_IE_RESET 1'h0

// Timing
`define SLB_CLK_NS 25
`define SLB_SSYN_NS 400
`define SLB_SSYN_CYC ((`SLB_SSYN_NS + `SLB_CLK_NS - 1) / `SLB_CLK_NS)
`define SLB_STROBE_NS 250
`define SLB_STROBE_CYC ((`SLB_STROBE_NS + `SLB_CLK_NS - 1) / `SLB_CLK_NS)

// Priority levels 4..7 on BR lines 0..3
`define SLB_BR_LOW 4
`define SLB_BR_LEVEL_DEF 4

`endif

// ===== hw/slb_pkg.sv
// Types shared by the serial line bus slave modules.
// Assumes nothing beyond a SystemVerilog compiler.
package slb_pkg;

   // Slave cycle sequencer
   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ACK} slb_bus_st_t;

   // Interrupt arbitration sequencer
   typedef enum logic [1:0] {I_IDLE, I_REQ, I_SACK, I_MASTER} slb_irq_st_t;

   // Interrupt source index
   typedef enum logic {SRC_RX, SRC_TX} slb_src_t;

endpackage

// ===== hw/slb_pulse_if.sv
// Trigger and busy pair between the slave logic and a one-shot.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface slb_pulse_if;
   logic trig;
   logic busy;
   modport src (output trig, input busy);
   modport shot (input trig, output busy);
endinterface

// ===== hw/slb_oneshot.sv
// Retrigger-proof one-shot that stretches a trigger into a fixed pulse.
// Assumes a synchronous trigger on the system clock.
`include "slb_map.svh"
`timescale 1ns/1ps
module slb_oneshot #(
   parameter int LEN = `SLB_STROBE_CYC
) (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Pulse pair
   slb_pulse_if.shot p
);

   logic [7:0] cnt_q, cnt_d;

   // Count down; a trigger while busy is ignored so the pulse never stretches
   always_comb begin
      cnt_d = cnt_q;
      if (cnt_q != 8'h00) begin
         cnt_d = cnt_q - 8'h01;
      end else if (p.trig) begin
         cnt_d = LEN[7:0];
      end
   end

   // Counter register
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 8'h00;
      end else if (ce) begin
         cnt_q <= cnt_d;
      end
   end

   assign p.busy = cnt_q != 8'h00;

   ////////////////////////////////////////////////////////////////////////
   property p_shot_len;
      @(posedge clk) disable iff (rst || !ce)
      (p.trig && !p.busy) |=> (cnt_q == LEN[7:0]);
   endproperty
   a_shot_len: assert property (p_shot_len)
      else $error("one-shot did not load its length");

   c_shot_fire: cover property (@(posedge clk) $rose(p.busy));

endmodule

// ===== hw/slb_bus_slave.sv
// Bus slave front end of the serial line interface: address decode,
// register read and write, acknowledge timing, strobes and interrupts.
// Assumes bus pins are asynchronous and the UART side is on CLK_SYS.
`include "slb_map.svh"
`timescale 1ns/1ps
module slb_bus_slave #(
   parameter int SSYN_CYC = `SLB_SSYN_CYC,
   parameter int STROBE_CYC = `SLB_STROBE_CYC,
   parameter int BR_LEVEL = `SLB_BR_LEVEL_DEF
) (
   // Clock, reset, enable
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic CE,
   // Straps
   input wire logic [`SLB_STRAP_W-1:0] ADDR_STRAP,
   input wire logic [`SLB_VSEL_W-1:0] VEC_STRAP,
   // Slave cycle lines
   input wire logic [`SLB_ADDR_W-1:0] BUS_A,
   input wire logic [1:0] BUS_C,
   input wire logic BUS_MSYN,
   input wire logic [`SLB_DATA_W-1:0] BUS_D_IN,
   output logic [`SLB_DATA_W-1:0] BUS_D_OUT,
   output logic BUS_D_OE,
   input wire logic BUS_SSYN_IN,
   output logic BUS_SSYN_OUT,
   output logic BUS_SSYN_OE,
   // Arbitration lines
   output logic [3:0] BUS_BR,
   input wire logic [3:0] BUS_BG_IN,
   output logic [3:0] BUS_BG_OUT,
   output logic BUS_SACK,
   input wire logic BUS_BBSY_IN,
   output logic BUS_BBSY_OUT,
   output logic BUS_BBSY_OE,
   output logic BUS_INTR,
   // UART side
   input wire logic RX_DONE,
   input wire logic [7:0] RX_DATA,
   input wire logic TX_READY,
   output logic [7:0] TX_DATA,
   output logic TX_LOAD,
   output logic RX_DONE_CLR
);

   localparam int SW = `SLB_ADDR_W + 2 + 1 + `SLB_DATA_W + 4 + 1 + 1;
   localparam logic [1:0] LVL = 2'(BR_LEVEL - `SLB_BR_LOW);
   localparam logic [7:0] SSYN_N = 8'(SSYN_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: the bus deskews address before MSYN, so one common
   // two-flop stage keeps address and strobe aligned
   logic [SW-1:0] sync1_q, sync2_q;
   logic [`SLB_ADDR_W-1:0] a_s;
   logic [1:0] c_s;
   logic msyn_s, ssyn_s, bbsy_s;
   logic [`SLB_DATA_W-1:0] d_s;
   logic [3:0] bg_s;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (CE) begin
         sync1_q <= {BUS_A, BUS_C, BUS_MSYN, BUS_D_IN, BUS_BG_IN,
                     BUS_SSYN_IN, BUS_BBSY_IN};
         sync2_q <= sync1_q;
      end
   end

   assign {a_s, c_s, msyn_s, d_s, bg_s, ssyn_s, bbsy_s} = sync2_q;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   logic base_hit, dev_hit, odd_wr, sel_en;
   logic [7:0] sel_vec;

   assign base_hit = &a_s[17:11];
   assign dev_hit = a_s[10:3] == ~ADDR_STRAP;
   assign odd_wr = a_s[0] & c_s[1];
   assign sel_en = msyn_s & base_hit & dev_hit & ~odd_wr;

   // One-hot function select, index {C1, A2, A1}
   always_comb begin
      sel_vec = 8'h00;
      if (sel_en) begin
         sel_vec[{c_s[1], a_s[2:1]}] = 1'b1;
      end
      sel_vec[`SLB_RD_NONE] = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register contents seen on reads
   logic rx_irq_enable_q, rx_irq_enable_d;
   logic tx_irq_enable_q, tx_irq_enable_d;
   logic [`SLB_DATA_W-1:0] rx_stat_val, tx_stat_val, rx_buf_val, rd_mux;
   logic [7:0] func_q, func_d;

   always_comb begin
      rx_stat_val = 16'h0000;
      rx_stat_val[`SLB_FLAG_BIT] = RX_DONE;
      rx_stat_val[`SLB_IE_BIT] = rx_irq_enable_q;
      tx_stat_val = 16'h0000;
      tx_stat_val[`SLB_FLAG_BIT] = TX_READY;
      tx_stat_val[`SLB_IE_BIT] = tx_irq_enable_q;
      rx_buf_val = {8'h00, RX_DATA};
      rd_mux = 16'h0000;
      if (func_q[`SLB_RD_RX_STAT]) rd_mux = rx_stat_val;
      if (func_q[`SLB_RD_RX_BUF]) rd_mux = rx_buf_val;
      if (func_q[`SLB_RD_TX_STAT]) rd_mux = tx_stat_val;
   end

   ////////////////////////////////////////////////////////////////////////
   // One-shots for the transmit load and the done clear
   slb_pulse_if tx_p ();
   slb_pulse_if rx_p ();

   slb_oneshot #(.LEN(STROBE_CYC)) u_tx_shot (
      .clk(CLK_SYS),
      .rst(RST),
      .ce(CE),
      .p(tx_p.shot)
   );

   slb_oneshot #(.LEN(STROBE_CYC)) u_rx_shot (
      .clk(CLK_SYS),
      .rst(RST),
      .ce(CE),
      .p(rx_p.shot)
   );

   assign TX_LOAD = tx_p.busy;
   assign RX_DONE_CLR = rx_p.busy;

   ////////////////////////////////////////////////////////////////////////
   // Slave cycle sequencer
   slb_pkg::slb_bus_st_t bst_q, bst_d;
   logic [7:0] cnt_q, cnt_d;
   logic [`SLB_DATA_W-1:0] dout_q, dout_d;
   logic doe_q, doe_d, ssyn_q, ssyn_d;
   logic [7:0] txd_q, txd_d;

   always_comb begin
      bst_d = bst_q;
      cnt_d = cnt_q;
      func_d = func_q;
      dout_d = dout_q;
      doe_d = doe_q;
      ssyn_d = ssyn_q;
      txd_d = txd_q;
      rx_irq_enable_d = rx_irq_enable_q;
      tx_irq_enable_d = tx_irq_enable_q;
      tx_p.trig = 1'b0;
      rx_p.trig = 1'b0;
      unique case (bst_q)
         slb_pkg::S_IDLE: begin
            // No match leaves the whole cycle to other slaves
            if (sel_en) begin
               bst_d = slb_pkg::S_WAIT;
               cnt_d = 8'h01;
               func_d = sel_vec;
               if (sel_vec[`SLB_WR_TX_BUF]) begin
                  tx_p.trig = 1'b1;
                  txd_d = d_s[7:0];
               end
               if (sel_vec[`SLB_RD_RX_BUF] || sel_vec[`SLB_WR_RX_BUF]) begin
                  rx_p.trig = 1'b1;
               end
               if (sel_vec[`SLB_WR_RX_STAT]) begin
                  rx_irq_enable_d = d_s[`SLB_IE_BIT];
               end
               if (sel_vec[`SLB_WR_TX_STAT]) begin
                  tx_irq_enable_d = d_s[`SLB_IE_BIT];
               end
            end
         end
         slb_pkg::S_WAIT: begin
            if (!msyn_s) begin
               bst_d = slb_pkg::S_IDLE;
               func_d = 8'h00;
               doe_d = 1'b0;
               dout_d = 16'h0000;
            end else begin
               if (cnt_q < SSYN_N) cnt_d = cnt_q + 8'h01;
               doe_d = |func_q[2:0];
               dout_d = rd_mux;
               // Holding off while loading keeps the D lines stable
               if (cnt_q >= SSYN_N && !tx_p.busy) begin
                  bst_d = slb_pkg::S_ACK;
                  ssyn_d = 1'b1;
               end
            end
         end
         slb_pkg::S_ACK: begin
            dout_d = rd_mux;
            if (!msyn_s) begin
               bst_d = slb_pkg::S_IDLE;
               func_d = 8'h00;
               ssyn_d = 1'b0;
               doe_d = 1'b0;
               dout_d = 16'h0000;
            end
         end
         default: bst_d = slb_pkg::S_IDLE;
      endcase
   end

   // Slave registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         bst_q <= slb_pkg::S_IDLE;
         cnt_q <= 8'h00;
         func_q <= 8'h00;
         dout_q <= 16'h0000;
         doe_q <= 1'b0;
         ssyn_q <= 1'b0;
         txd_q <= 8'h00;
         rx_irq_enable_q <= `SLB_IE_RESET;
         tx_irq_enable_q <= `SLB_IE_RESET;
      end else if (CE) begin
         bst_q <= bst_d;
         cnt_q <= cnt_d;
         func_q <= func_d;
         dout_q <= dout_d;
         doe_q <= doe_d;
         ssyn_q <= ssyn_d;
         txd_q <= txd_d;
         rx_irq_enable_q <= rx_irq_enable_d;
         tx_irq_enable_q <= tx_irq_enable_d;
      end
   end

   assign TX_DATA = txd_q;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt sources: index 0 receiver, 1 transmitter
   logic [1:0] cond, arm_q, arm_d, pend, taken;

   assign cond[0] = rx_irq_enable_q & RX_DONE;
   assign cond[1] = tx_irq_enable_q & TX_READY;

   // Each source rearms only after its level drops, which stops repeats
   for (genvar i = 0; i < 2; i++) begin : g_src
      always_comb begin
         arm_d[i] = arm_q[i];
         if (!cond[i]) begin
            arm_d[i] = 1'b1;
         end else if (taken[i]) begin
            arm_d[i] = 1'b0;
         end
      end
      always_ff @(posedge CLK_SYS) begin
         if (RST) begin
            arm_q[i] <= 1'b1;
         end else if (CE) begin
            arm_q[i] <= arm_d[i];
         end
      end
      assign pend[i] = cond[i] & arm_q[i];
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration sequencer
   slb_pkg::slb_irq_st_t ist_q, ist_d;
   slb_pkg::slb_src_t src_q, src_d;
   logic [`SLB_DATA_W-1:0] vec_q, vec_d;

   always_comb begin
      ist_d = ist_q;
      src_d = src_q;
      vec_d = vec_q;
      taken = 2'b00;
      unique case (ist_q)
         slb_pkg::I_IDLE: begin
            if (|pend) begin
               ist_d = slb_pkg::I_REQ;
               src_d = pend[0] ? slb_pkg::SRC_RX : slb_pkg::SRC_TX;
            end
         end
         slb_pkg::I_REQ: begin
            if (!pend[src_q]) begin
               ist_d = slb_pkg::I_IDLE;
            end else if (bg_s[LVL]) begin
               ist_d = slb_pkg::I_SACK;
            end
         end
         slb_pkg::I_SACK: begin
            if (!bbsy_s && !ssyn_s && !bg_s[LVL]) begin
               ist_d = slb_pkg::I_MASTER;
               vec_d = {7'h00, VEC_STRAP, src_q, 2'b00};
            end
         end
         slb_pkg::I_MASTER: begin
            // Processor strobed the vector in; give the bus back
            if (ssyn_s) begin
               ist_d = slb_pkg::I_IDLE;
               taken[src_q] = 1'b1;
               vec_d = 16'h0000;
            end
         end
      endcase
   end

   // Arbitration registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ist_q <= slb_pkg::I_IDLE;
         src_q <= slb_pkg::SRC_RX;
         vec_q <= 16'h0000;
      end else if (CE) begin
         ist_q <= ist_d;
         src_q <= src_d;
         vec_q <= vec_d;
      end
   end

   // Arbitration handshake outputs; grants pass on unless we asked
   always_comb begin
      BUS_BR = 4'h0;
      BUS_BG_OUT = bg_s;
      if (ist_q == slb_pkg::I_REQ) BUS_BR[LVL] = 1'b1;
      if (ist_q != slb_pkg::I_IDLE) BUS_BG_OUT[LVL] = 1'b0;
   end

   assign BUS_SACK = ist_q == slb_pkg::I_SACK;
   assign BUS_BBSY_OE = ist_q == slb_pkg::I_MASTER;
   assign BUS_BBSY_OUT = 1'b1;
   assign BUS_INTR = ist_q == slb_pkg::I_MASTER;
   assign BUS_SSYN_OUT = 1'b1;
   assign BUS_SSYN_OE = ssyn_q;
   assign BUS_D_OUT = dout_q | vec_q;
   assign BUS_D_OE = doe_q | BUS_INTR;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_onehot;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      $onehot0(sel_vec) && $onehot0(func_q) &&
         $onehot0({TX_LOAD, RX_DONE_CLR});
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("more than one select active");

   property p_ssyn_late;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (bst_q == slb_pkg::S_IDLE && sel_en) |=>
         !BUS_SSYN_OE [*8] ##1 !BUS_SSYN_OE [*7];
   endproperty
   a_ssyn_late: assert property (p_ssyn_late)
      else $error("acknowledge came too early");

   property p_ssyn_on;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (bst_q == slb_pkg::S_WAIT && cnt_q >= SSYN_N && msyn_s && !TX_LOAD)
         |=> BUS_SSYN_OE;
   endproperty
   a_ssyn_on: assert property (p_ssyn_on)
      else $error("acknowledge missing after delay");

   property p_load_hold;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      TX_LOAD |-> !BUS_SSYN_OE || $past(BUS_SSYN_OE);
   endproperty
   a_load_hold: assert property (p_load_hold)
      else $error("acknowledge rose during load strobe");

   property p_odd_byte;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (bst_q == slb_pkg::S_IDLE && odd_wr) |=>
         bst_q == slb_pkg::S_IDLE && !TX_LOAD && !RX_DONE_CLR;
   endproperty
   a_odd_byte: assert property (p_odd_byte)
      else $error("odd byte write produced a strobe");

   property p_nomatch;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (bst_q == slb_pkg::S_IDLE && !(base_hit && dev_hit)) |=>
         bst_q == slb_pkg::S_IDLE && !BUS_SSYN_OE && !doe_q;
   endproperty
   a_nomatch: assert property (p_nomatch)
      else $error("responded without address match");

   property p_transmit_buffer_reg_read;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (bst_q == slb_pkg::S_IDLE && sel_en && !c_s[1] && a_s[2:1] == 2'h3)
         |=> ##1 !doe_q && dout_q == 16'h0000;
   endproperty
   a_transmit_buffer_reg_read: assert property (p_transmit_buffer_reg_read)
      else $error("data driven for write-only register");

   property p_receive_buffer_reg_clr;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (bst_q == slb_pkg::S_IDLE && sel_en && a_s[2:1] == 2'h1 &&
       !RX_DONE_CLR) |=> RX_DONE_CLR;
   endproperty
   a_receive_buffer_reg_clr: assert property (p_receive_buffer_reg_clr)
      else $error("rx buffer access missed done clear");

   property p_rx_first;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (ist_q == slb_pkg::I_IDLE && pend == 2'b11) |=>
         src_q == slb_pkg::SRC_RX;
   endproperty
   a_rx_first: assert property (p_rx_first)
      else $error("transmitter served before receiver");

   property p_req_cause;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (BUS_BR != 4'h0) |-> BUS_BR[LVL] &&
         (src_q == slb_pkg::SRC_RX ? $past(cond[0]) : $past(cond[1]));
   endproperty
   a_req_cause: assert property (p_req_cause)
      else $error("request without enable and flag");

   property p_no_repeat;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      (|taken && cond[src_q]) |=> ##1 ist_q == slb_pkg::I_IDLE ||
         src_q != $past(src_q, 2);
   endproperty
   a_no_repeat: assert property (p_no_repeat)
      else $error("source rerequested without level drop");

   property p_vector;
      @(posedge CLK_SYS) disable iff (RST || !CE)
      BUS_INTR |-> BUS_D_OUT[2] == (src_q == slb_pkg::SRC_TX) &&
         BUS_D_OUT[8:3] == VEC_STRAP && BUS_D_OUT[1:0] == 2'b00;
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector does not match source");

   c_read: cover property (@(posedge CLK_SYS) doe_q && BUS_SSYN_OE);
   c_transmit_buffer_reg: cover property (@(posedge CLK_SYS) $rose(TX_LOAD));
   c_rx_irq: cover property (@(posedge CLK_SYS)
      BUS_INTR && src_q == slb_pkg::SRC_RX);
   c_tx_irq: cover property (@(posedge CLK_SYS)
      BUS_INTR && src_q == slb_pkg::SRC_TX);

endmodule

// ===== verification/slb_cpu_model.sv
// Processor side model: bus master cycles and interrupt vector intake.
// Assumes the bench clock; every line changes at the falling edge.
`timescale 1ns/1ps
module slb_cpu_model (
   // Clock
   input wire logic clk,
   // Slave cycle lines
   output logic [17:0] a,
   output logic [1:0] c,
   output logic msyn,
   output logic [15:0] d,
   input wire logic [15:0] d_out,
   input wire logic d_oe,
   input wire logic ssyn_oe,
   // Arbitration lines
   input wire logic [3:0] br,
   input wire logic sack,
   input wire logic intr,
   output logic [3:0] bg,
   output logic vssyn,
   // Strobes watched during a cycle
   input wire logic ld,
   input wire logic clr
);
   logic [15:0] vecs[$];
   logic [3:0] br_seen;

   // Idle bus: pulled-up lines read as not asserted
   initial begin
      a = 18'h0;
      c = 2'h0;
      msyn = 1'b0;
      d = 16'h0;
      bg = 4'h0;
      vssyn = 1'b0;
      br_seen = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One slave cycle; lines held until the acknowledge is seen or 40 cycles pass without one
   task automatic cycle(input logic [17:0] ta, input logic [1:0] tc,
      input logic [15:0] td, output logic ack, output logic [15:0] rd,
      output logic doe, output int lat, output int nld, output int ncl,
      output logic ld_ack);
      ack = 1'b0;
      rd = 16'h0;
      doe = 1'b0;
      ld_ack = 1'b0;
      lat = 0;
      nld = 0;
      ncl = 0;
      @(negedge clk);
      a = ta;
      c = tc;
      d = td;
      // Address and data settle before sync goes up
      repeat (2) @(negedge clk);
      msyn = 1'b1;
      for (int i = 0; i < 40 && !ack; i++) begin
         @(negedge clk);
         lat++;
         nld += int'(ld === 1'b1);
         ncl += int'(clr === 1'b1);
         if (ssyn_oe === 1'b1) begin
            ack = 1'b1;
            rd = d_out;
            doe = d_oe;
            ld_ack = ld;
         end
      end
      msyn = 1'b0;
      for (int i = 0; i < 8 && ssyn_oe !== 1'b0; i++) @(negedge clk);
      // Released lines fall back to the idle level
      a = 18'h0;
      c = 2'h0;
      d = 16'h0;
      @(negedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Grant what is asked until acknowledged; strobe the vector in
   always @(negedge clk) begin
      br_seen = br_seen | br;
      bg = br & {4{~sack}};
      if (intr === 1'b1 && d_oe === 1'b1 && !vssyn) begin
         vecs.push_back(d_out);
         vssyn = 1'b1;
      end else if (intr !== 1'b1) begin
         vssyn = 1'b0;
      end
   end
endmodule

// ===== verification/test_serial_line_bus_slave_decode.sv
// Self-checking bench for the bus slave with a processor model.
// Assumes the design files and slb_cpu_model are compiled first.
`timescale 1ns/1ps
module test_serial_line_bus_slave_decode;
   // Strobe outlasts the acknowledge delay so the hold-off is exercised
   localparam int STROBE = 17;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic rx_done = 1'b0;
   logic tx_ready = 1'b0;
   logic [7:0] rx_data = 8'h0;
   logic [7:0] strap = 8'h0;
   logic [5:0] vstrap = 6'h06; // Console vector 060
   logic [31:0] rng = 32'hbd73;
   logic [17:0] a;
   logic [1:0] c;
   logic [15:0] d_in, d_out;
   logic [3:0] br, bg_in;
   logic [7:0] tx_data;
   logic msyn, d_oe, ssyn_oe, sack, intr, bbsy_oe, vssyn, ld, clr;
   int n_errors = 0;
   int n_tests = 0;

   always #12.5 clk_sys = ~clk_sys;

   slb_bus_slave #(.SSYN_CYC(16), .STROBE_CYC(STROBE), .BR_LEVEL(4)) dut_u (
      .CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .ADDR_STRAP(strap),
      .VEC_STRAP(vstrap), .BUS_A(a), .BUS_C(c), .BUS_MSYN(msyn),
      .BUS_D_IN(d_in), .BUS_D_OUT(d_out), .BUS_D_OE(d_oe),
      .BUS_SSYN_IN(ssyn_oe | vssyn), .BUS_SSYN_OUT(), .BUS_SSYN_OE(ssyn_oe),
      .BUS_BR(br), .BUS_BG_IN(bg_in), .BUS_BG_OUT(), .BUS_SACK(sack),
      .BUS_BBSY_IN(bbsy_oe), .BUS_BBSY_OUT(), .BUS_BBSY_OE(bbsy_oe),
      .BUS_INTR(intr), .RX_DONE(rx_done), .RX_DATA(rx_data),
      .TX_READY(tx_ready), .TX_DATA(tx_data), .TX_LOAD(ld),
      .RX_DONE_CLR(clr));

   slb_cpu_model cpu_u (.clk(clk_sys), .a(a), .c(c), .msyn(msyn),
      .d(d_in), .d_out(d_out), .d_oe(d_oe), .ssyn_oe(ssyn_oe), .br(br),
      .sack(sack), .intr(intr), .bg(bg_in), .vssyn(vssyn), .ld(ld),
      .clr(clr));

   ////////////////////////////////////////////////////////////////////////
   // Expectation helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [17:0] adr(input logic [1:0] sel);
      return {7'h7f, ~strap, sel, 1'b0};
   endfunction
   function automatic logic [15:0] st(input logic f, input logic e);
      return {8'h0, f, e, 6'h0};
   endfunction
   function automatic logic [15:0] vec(input logic src);
      return {7'h0, vstrap, src, 2'h0};
   endfunction

   task automatic chk_v(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      n_tests++;
      if (e !== g) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_n(input string nm, input int e, input int g);
      n_tests++;
      if (e != g) begin
         n_errors++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   // One cycle; e is {acknowledge, data enable}
   task automatic op(input logic [17:0] ta, input logic [1:0] tc,
      input logic [15:0] td, input logic [1:0] e, input logic [15:0] erd,
      input int eld, input int ecl);
      logic ack, doe, lda;
      logic [15:0] rd;
      int lat, nld, ncl;
      cpu_u.cycle(ta, tc, td, ack, rd, doe, lat, nld, ncl, lda);
      chk_v("ack", {15'h0, e[1]}, {15'h0, ack});
      chk_v("data enable", {15'h0, e[0]}, {15'h0, doe});
      if (e[0]) chk_v("read data", erd, rd);
      chk_n("load cycles", eld, nld);
      chk_n("clear cycles", ecl, ncl);
      if (e[1]) chk_n("ack late", 1, int'(lat >= 16 && lat <= 24));
      if (e[1]) chk_v("load at ack", 16'h0, {15'h0, lda});
   endtask

   task automatic wait_vec(input int n);
      for (int i = 0; i < 400 && cpu_u.vecs.size() < n; i++)
         @(negedge clk_sys);
      chk_n("vector count", n, cpu_u.vecs.size());
   endtask

   task automatic results;
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rng = xs(rng);
      strap = rng[7:0];
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      op(adr(2'h0), 2'h0, 16'h0, 2'h3, st(1'b0, 1'b0), 0, 0);
      rx_done = 1'b1;
      op(adr(2'h0), 2'h1, 16'h0, 2'h3, st(1'b1, 1'b0), 0, 0);
      rx_done = 1'b0;
      op(adr(2'h2), 2'h0, 16'h0, 2'h3, st(1'b0, 1'b0), 0, 0);
      $display("test status reads done");
      for (int i = 0; i < 3; i++) begin
         rng = xs(rng);
         rx_data = rng[7:0];
         op(adr(2'h1), 2'h2, rng[31:16], 2'h2, 16'h0, 0, STROBE);
         op(adr(2'h1), 2'h0, 16'h0, 2'h3, {8'h0, rx_data}, 0, STROBE);
      end
      for (int i = 0; i < 3; i++) begin
         rng = xs(rng);
         op(adr(2'h3), {1'b1, rng[0]}, rng[31:16], 2'h2, 16'h0, STROBE,
            0);
         chk_v("tx data", {8'h0, rng[23:16]}, {8'h0, tx_data});
      end
      $display("test buffers done");
      op(adr(2'h3) | 18'h1, 2'h3, 16'hffff, 2'h0, 16'h0, 0, 0);
      op(adr(2'h3), 2'h0, 16'h0, 2'h2, 16'h0, 0, 0);
      rng = xs(rng);
      op(adr(2'h0) ^ (18'h8 << rng[2:0]), 2'h0, 16'h0, 2'h0, 16'h0,
         0, 0);
      op(adr(2'h1) ^ (18'h800 << (rng[5:3] % 7)), 2'h0, 16'h0, 2'h0,
         16'h0, 0, 0);
      $display("test decode done");
      // Enables on while both flags are low
      op(adr(2'h0), 2'h2, rng[15:0] | 16'h0040, 2'h2, 16'h0, 0, 0);
      op(adr(2'h2), 2'h2, rng[31:16] | 16'h0040, 2'h2, 16'h0, 0, 0);
      op(adr(2'h0), 2'h0, 16'h0, 2'h3, st(1'b0, 1'b1), 0, 0);
      op(adr(2'h2), 2'h0, 16'h0, 2'h3, st(1'b0, 1'b1), 0, 0);
      rx_done = 1'b1;
      tx_ready = 1'b1;
      wait_vec(2);
      chk_v("first vector", vec(1'b0), cpu_u.vecs[0]);
      chk_v("second vector", vec(1'b1), cpu_u.vecs[1]);
      chk_v("request lines", 16'h1, {12'h0, cpu_u.br_seen});
      repeat (100) @(negedge clk_sys);
      chk_n("vectors held", 2, cpu_u.vecs.size());
      rx_done = 1'b0;
      repeat (3) @(negedge clk_sys);
      rx_done = 1'b1;
      wait_vec(3);
      chk_v("rearmed vector", vec(1'b0), cpu_u.vecs[2]);
      // Flag alone, enable off, must not request
      op(adr(2'h0), 2'h2, 16'h0, 2'h2, 16'h0, 0, 0);
      rx_done = 1'b0;
      repeat (3) @(negedge clk_sys);
      rx_done = 1'b1;
      repeat (100) @(negedge clk_sys);
      chk_n("masked vectors", 3, cpu_u.vecs.size());
      $display("test interrupts done");
      results;
   end
endmodule
